// *** mp_decode_pkg.sv ***
package mp_decode_pkg;

  // class and field positions of the long-immediate / three-register format
  localparam int CLASS_HI_POS = 21;
  localparam int CLASS_LO_POS = 20;
  localparam int OPC_HI = 19;
  localparam int OPC_LO = 13;
  localparam int LIMM_POS = 12;
  localparam int MOD_POS = 15;
  localparam int SIZE_HI = 14;
  localparam int SIZE_LO = 13;
  localparam int SCALE_POS = 11;
  localparam int DIRECT_POS = 10;
  localparam int ANNUL_POS = 13;
  localparam int EMU_POS = 27;
  localparam int FLAGS_POS = 27;
  localparam int INV_POS = 11;
  localparam int ROT_SENSE_POS = 10;
  localparam int DEST_HI = 31;
  localparam int DEST_LO = 27;
  localparam int SRC2_HI = 26;
  localparam int SRC2_LO = 22;
  localparam int SRC1_HI = 4;
  localparam int SRC1_LO = 0;
  localparam int EMASK_HI = 9;
  localparam int EMASK_LO = 5;

  // access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_DOUBLE = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE, OP_TRAP, OP_CMND, OP_RDCR, OP_SWCR, OP_BRCR, OP_SHIFT,
    OP_LOGIC, OP_LOAD, OP_LOADU, OP_STORE, OP_DCACHE, OP_BRANCH,
    OP_CMP, OP_ADD, OP_SUB
  } op_class_e;

  // decoded controls handed to the execute stages
  typedef struct packed {
    logic valid;
    logic illegal;
    op_class_e op;
    logic [6:0] opc;
    logic [4:0] dest;
    logic [4:0] src2;
    logic [4:0] src1;
    logic [31:0] operand;
    logic use_limm;
    logic [3:0] size_bytes;
    logic writeback;
    logic scale;
    logic direct_ext;
    logic annul_taken;
    logic emu_trap;
    logic clear_flags;
    logic rot_sense;
    logic inv_mask;
    logic [4:0] endmask;
  } dec_out_s;

endpackage : mp_decode_pkg

// *** mp_op_match.sv ***
`timescale 1ns/10ps
// classifies the seven opcode bits of the long/three-register format
module mp_op_match
  import mp_decode_pkg::*;
(
  input wire logic [6:0] opc_i,
  output op_class_e op_o
);

  // opcode table; unlisted codes give OP_NONE
  always_comb begin
    op_o = OP_NONE;
    case (opc_i)
      7'h01: op_o = OP_TRAP;
      7'h02: op_o = OP_CMND;
      7'h04: op_o = OP_RDCR;
      7'h05: op_o = OP_SWCR;
      7'h06: op_o = OP_BRCR;
      7'h11, 7'h12, 7'h14, 7'h16, 7'h17: op_o = OP_LOGIC;
      7'h18, 7'h19, 7'h1B, 7'h1D, 7'h1E: op_o = OP_LOGIC;
      7'h38, 7'h3C: op_o = OP_DCACHE; // opcode bit 2 is the modify bit
      7'h50: op_o = OP_CMP;
      7'h58, 7'h59: op_o = OP_ADD;
      7'h5A, 7'h5B: op_o = OP_SUB;
      default: begin
        // the shift group, and groups whose low opcode bits carry modify, size or annul
        if (opc_i[6:3] == 4'h1) op_o = OP_SHIFT;
        else if (opc_i[6:3] == 4'h4) op_o = OP_LOAD;
        else if (opc_i[6:3] == 4'h5) op_o = OP_LOADU;
        else if (opc_i[6:3] == 4'h6) op_o = OP_STORE;
        else if (opc_i[6:3] == 4'h8 && !opc_i[1]) op_o = OP_BRANCH;
        else if (opc_i[6:3] == 4'h9 && opc_i[2:1] != 2'h3) op_o = OP_BRANCH;
        else op_o = OP_NONE;
      end
    endcase
  end

endmodule : mp_op_match

// *** mp_long_decode.sv ***
`timescale 1ns/10ps
// Functional notes
// RULE1 - bits 21 and 20 both set select this format class
// RULE2 - access size field: 0 byte, 1 halfword, 2 word, 3 doubleword
// RULE3 - modify bit on load, store, cache flush writes address back
// RULE4 - annul bit suppresses delay slot only when branch taken
// RULE5 - direct bit sends load or store straight to external memory
// RULE6 - shift rotate-sense picks direction; invert bit complements endmask
// RULE7 - trap passes its emulation-trap bit on
// RULE8 - cache flush flag bit also clears sub-block present flags
// RULE9 - producers code every reserved bit as zero
// RULE10 - long-immediate bit takes next 32-bit word as operand; the code ignores the bit on shifts
// RULE11 - scale bit multiplies offset by access size in bytes
// RULE12 - encodings matching no listed pattern are flagged illegal
module mp_long_decode
  import mp_decode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic imm_valid_i,
  input wire logic [31:0] imm_i,
  input wire logic branch_taken_i,
  output logic imm_wait_o,
  output logic annul_slot_o,
  output dec_out_s dec_o
);

  typedef enum {ST_IDLE, ST_IMM} dec_state_e;

  dec_state_e state_q;
  dec_out_s held_q;
  dec_out_s cur_d;
  op_class_e op_w;
  logic [6:0] opc_w;
  logic class_hit_w;
  logic annul_pend_q;

  assign opc_w = instr_i[OPC_HI:OPC_LO];
  assign class_hit_w = instr_i[CLASS_HI_POS] & instr_i[CLASS_LO_POS]; // RULE1

  mp_op_match u_match (
    .opc_i(opc_w),
    .op_o(op_w)
  );

  // field extraction for one instruction word
  always_comb begin
    logic mem_w;
    mem_w = 1'b0;
    cur_d = '0;
    cur_d.valid = instr_valid_i;
    cur_d.op = class_hit_w ? op_w : OP_NONE; // RULE1
    cur_d.illegal = instr_valid_i
                    & (!class_hit_w || op_w == OP_NONE); // RULE12
    cur_d.opc = opc_w;
    cur_d.dest = instr_i[DEST_HI:DEST_LO];
    cur_d.src2 = instr_i[SRC2_HI:SRC2_LO];
    cur_d.src1 = instr_i[SRC1_HI:SRC1_LO];
    cur_d.use_limm = instr_i[LIMM_POS] && cur_d.op != OP_SHIFT; // RULE10
    mem_w = cur_d.op inside {OP_LOAD, OP_LOADU, OP_STORE};
    if (mem_w) begin
      case (instr_i[SIZE_HI:SIZE_LO]) // RULE2
        SIZE_BYTE: cur_d.size_bytes = 4'h1;
        SIZE_HALF: cur_d.size_bytes = 4'h2;
        SIZE_WORD: cur_d.size_bytes = 4'h4;
        default: cur_d.size_bytes = 4'h8;
      endcase
      cur_d.scale = instr_i[SCALE_POS]; // RULE11
      cur_d.direct_ext = instr_i[DIRECT_POS]; // RULE5
    end
    cur_d.writeback = (mem_w || cur_d.op == OP_DCACHE)
                      && instr_i[MOD_POS]; // RULE3
    cur_d.annul_taken = cur_d.op == OP_BRANCH && instr_i[ANNUL_POS];
    cur_d.emu_trap = cur_d.op == OP_TRAP && instr_i[EMU_POS]; // RULE7
    cur_d.clear_flags = cur_d.op == OP_DCACHE && instr_i[FLAGS_POS]; // RULE8
    if (cur_d.op == OP_SHIFT) begin
      cur_d.rot_sense = instr_i[ROT_SENSE_POS]; // RULE6
      cur_d.inv_mask = instr_i[INV_POS]; // RULE6
      cur_d.endmask = instr_i[EMASK_HI:EMASK_LO];
    end
    // reserved bits are assumed zero and not checked (RULE9 on producers)
    cur_d.operand = {27'h0, cur_d.src1};
  end

  // instruction / immediate sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      held_q <= '0;
      dec_o <= '0;
      imm_wait_o <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (instr_valid_i && cur_d.use_limm && !cur_d.illegal) begin
            held_q <= cur_d;
            state_q <= ST_IMM;
            imm_wait_o <= 1'b1;
            dec_o <= '0;
          end else begin
            dec_o <= cur_d;
          end
        end
        ST_IMM: begin
          dec_o <= '0;
          if (imm_valid_i) begin
            dec_o <= held_q;
            dec_o.operand <= imm_i; // RULE10
            state_q <= ST_IDLE;
            imm_wait_o <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // delay-slot annulment once the branch outcome is known
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      annul_pend_q <= 1'b0;
      annul_slot_o <= 1'b0;
    end else begin
      annul_slot_o <= annul_pend_q && branch_taken_i; // RULE4
      annul_pend_q <= dec_o.valid && dec_o.annul_taken;
    end
  end

  property p_class_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    (instr_valid_i && state_q == ST_IDLE && !instr_i[CLASS_LO_POS])
      |=> dec_o.illegal;
  endproperty
  a_class_gate: assert property (p_class_gate) // RULE1
    else $error("bad class");

  property p_illegal_none;
    @(posedge clk_i) disable iff (!rst_n_i)
    dec_o.illegal |-> dec_o.op == OP_NONE || !dec_o.valid;
  endproperty
  a_illegal_none: assert property (p_illegal_none) // RULE12
    else $error("illegal op");

  property p_size;
    @(posedge clk_i) disable iff (!rst_n_i)
    (instr_valid_i && state_q == ST_IDLE && cur_d.op == OP_LOAD
     && !instr_i[LIMM_POS] && instr_i[SIZE_HI:SIZE_LO] == SIZE_DOUBLE)
      |=> dec_o.size_bytes == 4'h8;
  endproperty
  a_size: assert property (p_size) // RULE2
    else $error("size wrong");

  property p_wb;
    @(posedge clk_i) disable iff (!rst_n_i)
    dec_o.writeback
      |-> dec_o.op inside {OP_LOAD, OP_LOADU, OP_STORE, OP_DCACHE};
  endproperty
  a_wb: assert property (p_wb) // RULE3
    else $error("writeback op");

  sequence s_annul_branch;
    dec_o.valid && dec_o.annul_taken ##1 branch_taken_i;
  endsequence
  property p_annul;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_annul_branch |=> annul_slot_o;
  endproperty
  a_annul: assert property (p_annul) // RULE4
    else $error("no annul");

  property p_no_annul;
    @(posedge clk_i) disable iff (!rst_n_i)
    annul_slot_o |-> $past(branch_taken_i);
  endproperty
  a_no_annul: assert property (p_no_annul) // RULE4
    else $error("spurious annul");

  property p_direct;
    @(posedge clk_i) disable iff (!rst_n_i)
    dec_o.direct_ext |-> dec_o.op inside {OP_LOAD, OP_LOADU, OP_STORE};
  endproperty
  a_direct: assert property (p_direct) // RULE5
    else $error("direct op");

  property p_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
    dec_o.clear_flags |-> dec_o.op == OP_DCACHE;
  endproperty
  a_flags: assert property (p_flags) // RULE8
    else $error("flags op");

  sequence s_limm_start;
    state_q == ST_IDLE && instr_valid_i && cur_d.use_limm && !cur_d.illegal;
  endsequence
  property p_limm;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_limm_start ##1 imm_valid_i
      |=> dec_o.valid && dec_o.operand == $past(imm_i);
  endproperty
  a_limm: assert property (p_limm) // RULE10
    else $error("imm operand");

  // option bits of shifts pass straight through to the execute stage
  property p_shift_bits;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && instr_valid_i && cur_d.op == OP_SHIFT)
      |=> dec_o.inv_mask == $past(instr_i[INV_POS])
          && dec_o.rot_sense == $past(instr_i[ROT_SENSE_POS])
          && dec_o.endmask == $past(instr_i[EMASK_HI:EMASK_LO]);
  endproperty
  a_shift_bits: assert property (p_shift_bits) // RULE6
    else $error("shift bits");

  property p_emu;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && instr_valid_i && cur_d.op == OP_TRAP
     && !instr_i[LIMM_POS])
      |=> dec_o.emu_trap == $past(instr_i[EMU_POS]);
  endproperty
  a_emu: assert property (p_emu) // RULE7
    else $error("emulation bit");

  property p_scale;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && instr_valid_i && !instr_i[LIMM_POS]
     && cur_d.op inside {OP_LOAD, OP_LOADU, OP_STORE})
      |=> dec_o.scale == $past(instr_i[SCALE_POS]);
  endproperty
  a_scale: assert property (p_scale) // RULE11
    else $error("scale bit");

  // a word in this class that matches no opcode must come out flagged
  property p_unlisted;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state_q == ST_IDLE && instr_valid_i && class_hit_w && op_w == OP_NONE)
      |=> dec_o.valid && dec_o.illegal;
  endproperty
  a_unlisted: assert property (p_unlisted) // RULE12
    else $error("unlisted opcode");

  // nothing leaves the decoder while the immediate word is awaited
  sequence s_imm_pending;
    imm_wait_o && !imm_valid_i;
  endsequence
  property p_imm_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_imm_pending |=> imm_wait_o && !dec_o.valid;
  endproperty
  a_imm_hold: assert property (p_imm_hold) // RULE10
    else $error("left wait early");

endmodule : mp_long_decode

// *** mp_fetch_model.sv ***
`timescale 1ns/10ps
// fetch side: hands the 32-bit word that follows a long-immediate instruction
module mp_fetch_model (
  input wire logic clk_i,
  input wire logic imm_wait_i,
  input wire logic [1:0] lag_i,
  input wire logic [31:0] word_i,
  output logic imm_valid_o,
  output logic [31:0] imm_o
);
  logic [1:0] cnt_q;
  initial begin
    imm_valid_o = 1'b0;
    imm_o = 32'h0;
    cnt_q = 2'h0;
  end
  // answer after lag_i cycles; the data line toggles while idle
  always @(negedge clk_i) begin
    cnt_q <= imm_wait_i ? cnt_q + 2'h1 : 2'h0;
    imm_valid_o <= imm_wait_i && (cnt_q >= lag_i);
    imm_o <= imm_wait_i ? word_i : ~imm_o;
  end
endmodule : mp_fetch_model

// *** tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import mp_decode_pkg::*;
  logic clk, rst_n, instr_valid, imm_valid, branch_taken, imm_wait, annul;
  logic [31:0] instr, imm, word;
  logic [1:0] lag;
  dec_out_s dec;
  int fails = 0, total_checks = 0, cyc = 0, n;
  mp_long_decode dut_u (.clk_i(clk), .rst_n_i(rst_n),
    .instr_valid_i(instr_valid), .instr_i(instr), .imm_valid_i(imm_valid),
    .imm_i(imm), .branch_taken_i(branch_taken), .imm_wait_o(imm_wait),
    .annul_slot_o(annul), .dec_o(dec));
  mp_fetch_model fetch_u (.clk_i(clk), .imm_wait_i(imm_wait), .lag_i(lag),
    .word_i(word), .imm_valid_o(imm_valid), .imm_o(imm));
  // reserved positions are always built as zero
  function automatic logic [31:0] mk(logic [4:0] d, logic [6:0] o,
    logic l, logic [11:0] lo);
    return {d, 5'h06, 2'h3, o, l, lo};
  endfunction : mk
  task automatic issue(input logic [31:0] w);
    @(negedge clk);
    instr_valid = 1'b1;
    instr = w;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : issue
  task automatic t_load;
    for (int s = 0; s < 4; s++) begin
      issue(mk(5'h02, {5'h09, s[1:0]}, 1'b0, 12'hC05));
      `CHK("valid", 1'b1, dec.valid)
      `CHK("op", OP_LOAD, dec.op)
      `CHK("dest", 5'h02, dec.dest)
      `CHK("base", 5'h06, dec.src2)
      `CHK("size", 4'h1 << s, dec.size_bytes)
      `CHK("wb", 1'b1, dec.writeback)
      `CHK("scale", 1'b1, dec.scale)
      `CHK("direct", 1'b1, dec.direct_ext)
    end
    issue(mk(5'h02, {5'h0C, SIZE_WORD}, 1'b0, 12'h003));
    `CHK("st_size", 4'h4, dec.size_bytes)
    `CHK("st_opc", 7'h32, dec.opc)
    `CHK("st_wb", 1'b0, dec.writeback)
    `CHK("st_scale", 1'b0, dec.scale)
    `CHK("st_direct", 1'b0, dec.direct_ext)
    `CHK("operand", 32'h3, dec.operand)
    $display("test load_store done");
  endtask : t_load
  task automatic t_shift;
    for (int k = 0; k < 2; k++) begin
      issue(mk(5'h01, 7'h0D, 1'b0, {k[0], ~k[0], 5'h0A, 5'h03}));
      `CHK("op", OP_SHIFT, dec.op)
      `CHK("inv", k[0], dec.inv_mask)
      `CHK("rot", ~k[0], dec.rot_sense)
      `CHK("emask", 5'h0A, dec.endmask)
    end
    $display("test shift done");
  endtask : t_shift
  task automatic t_misc;
    issue(mk(5'h01, 7'h01, 1'b0, 12'h000));
    `CHK("trap", OP_TRAP, dec.op)
    `CHK("emu", 1'b1, dec.emu_trap)
    issue(mk(5'h01, 7'h3C, 1'b0, 12'h004));
    `CHK("dc", OP_DCACHE, dec.op)
    `CHK("flags", 1'b1, dec.clear_flags)
    `CHK("dc_wb", 1'b1, dec.writeback)
    issue(mk(5'h01, 7'h58, 1'b0, 12'h000) ^ 32'h0010_0000);
    `CHK("cls", 1'b1, dec.illegal)
    issue(mk(5'h01, 7'h7F, 1'b0, 12'h000));
    `CHK("unlisted", 1'b1, dec.illegal)
    issue(mk(5'h01, 7'h58, 1'b0, 12'h000));
    `CHK("add", 1'b0, dec.illegal)
    `CHK("add_op", OP_ADD, dec.op)
    $display("test misc done");
  endtask : t_misc
  task automatic t_annul;
    for (int k = 0; k < 3; k++) begin
      issue(mk(5'h01, {6'h20, k < 2}, 1'b0, 12'h000));
      `CHK("annul_bit", k < 2, dec.annul_taken)
      branch_taken = (k != 1);
      n = 0;
      repeat (3) begin
        @(negedge clk);
        n += (annul === 1'b1);
      end
      branch_taken = 1'b0;
      `CHK("slot", (k == 0), n)
    end
    $display("test annul done");
  endtask : t_annul
  task automatic t_limm;
    for (int k = 0; k < 3; k += 2) begin
      lag = k[1:0];
      word = 32'hA5C3_0F1E + k;
      issue(mk(5'h01, 7'h58, 1'b1, 12'h000));
      `CHK("wait", 1'b1, imm_wait)
      repeat (8) if (dec.valid !== 1'b1) @(negedge clk);
      `CHK("imm", word, dec.operand)
      `CHK("use", 1'b1, dec.use_limm)
      `CHK("wait_end", 1'b0, imm_wait)
    end
    $display("test long_immediate done");
  endtask : t_limm
  // one word of each remaining opcode group, plus an unlisted code
  task automatic t_opcodes;
    logic [6:0] codes [12] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h1E, 7'h2B,
      7'h50, 7'h5B, 7'h4D, 7'h45, 7'h38, 7'h13};
    op_class_e kinds [12] = '{OP_CMND, OP_RDCR, OP_SWCR, OP_BRCR, OP_LOGIC,
      OP_LOADU, OP_CMP, OP_SUB, OP_BRANCH, OP_BRANCH, OP_DCACHE, OP_NONE};
    for (int k = 0; k < 12; k++) begin
      issue(mk(5'h01, codes[k], 1'b0, 12'h000));
      `CHK("class", kinds[k], dec.op)
      `CHK("ill", kinds[k] == OP_NONE, dec.illegal)
    end
    $display("test opcodes done");
  endtask : t_opcodes
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, instr_valid, branch_taken, instr, lag, word} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_load();
    t_shift();
    t_misc();
    t_annul();
    t_limm();
    t_opcodes();
    print_verdict();
  end
endmodule : tb_top
